/* scie_pkg.sv */
`default_nettype none
package scie_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned RESTORE_MS      = 800;
  localparam int unsigned RESTORE_REVS    = 16;
  localparam int unsigned RESTORE_CYCLES  = (RESTORE_MS * 1000000) / CLK_PERIOD_NS;

  // ==========================================================================
  // codes and field layout
  localparam int unsigned BYTE_W          = 12;
  localparam int unsigned UNIT_N          = 4;
  localparam int unsigned UNIT_W          = 2;
  localparam int unsigned ADDR_W          = 24;
  localparam int unsigned SECT_W          = 8;
  localparam int unsigned SEL_N           = 5;
  localparam int unsigned SEL_W           = 3;
  localparam logic [5:0]  FN_GROUP_ADDR   = 6'h01;
  localparam logic [5:0]  FN_GROUP_IO     = 6'h04;
  localparam logic [BYTE_W-1:0] FN_CKW_VERIFY = 12'h024;
  localparam logic [5:0]  FN_GROUP_SEL    = 6'h02;
  localparam logic [5:0]  FN_GROUP_REL    = 6'h03;
  localparam logic [5:0]  FN_CLEAR        = 6'h00;
  localparam logic [5:0]  FN_RELEASE      = 6'h05;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;

  // interrupt selection bit positions
  localparam int unsigned SEL_READY       = 0;
  localparam int unsigned SEL_FINISH      = 1;
  localparam int unsigned SEL_ABN_FINISH  = 2;
  localparam int unsigned SEL_SEEK        = 3;
  localparam int unsigned SEL_OPP_REL     = 4;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic              valid;
    logic              is_connect;
    logic              is_function;
    logic              is_data;
    logic [BYTE_W-1:0] word;
    logic              par;
  } scie_chan_req_t;

  typedef struct packed {
    logic reply;
    logic reject;
    logic link_par_err;
    logic irq;
    logic lockout_override;
  } scie_chan_rsp_t;

  typedef enum logic [4:0] {
    SCIE_IDLE   = 5'b00001,
    SCIE_SEEK   = 5'b00010,
    SCIE_VERIFY = 5'b00100,
    SCIE_XFER   = 5'b01000,
    SCIE_PAD    = 5'b10000
  } scie_op_state_t;

  // ==========================================================================
  // odd parity over a 12-bit byte: bit set when the word has even weight
  function automatic logic scie_odd_par(input logic [BYTE_W-1:0] w);
    return ~(^w);
  endfunction

endpackage : scie_pkg
`default_nettype wire

/* scie_parity_chk.sv */
`default_nettype none
module scie_parity_chk
  import scie_pkg::*;
(
  input  wire logic           mclk_i,
  input  wire logic           rst_n_i,
  input  wire scie_chan_req_t req_i,
  output logic                conn_err_o,
  output logic                fn_err_o,
  output logic                data_err_o,
  output logic                indicator_o
);

  logic bad;
  logic ind_ff;
  logic nxt_ind;

  // ==========================================================================
  // check
  always_comb begin
    bad         = req_i.valid && (scie_odd_par(req_i.word) != req_i.par);
    conn_err_o  = bad && req_i.is_connect;
    fn_err_o    = bad && req_i.is_function;
    data_err_o  = bad && req_i.is_data;
    // indicator is sticky until reset: it is a panel lamp, not a status bit
    nxt_ind     = ind_ff | bad;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ind_ff <= 1'b0;
    end else begin
      ind_ff <= nxt_ind;
    end
  end

  assign indicator_o = ind_ff;

endmodule // scie_parity_chk
`default_nettype wire

/* scie_restore_tmr.sv */
`default_nettype none
module scie_restore_tmr
  import scie_pkg::*;
#(
  parameter int unsigned RESTORE_CYC = RESTORE_CYCLES
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  input  wire logic              strip_i,
  input  wire logic              release_i,
  input  wire logic              readdress_i,
  input  wire logic [UNIT_W-1:0] unit_i,
  output logic                   restore_o,
  output logic [UNIT_W-1:0]      restore_unit_o
);

  logic [24:0]       cnt_ff;
  logic [24:0]       nxt_cnt;
  logic              arm_ff;
  logic              nxt_arm;
  logic [UNIT_W-1:0] unit_ff;
  logic [UNIT_W-1:0] nxt_unit;
  logic              pulse_ff;
  logic              nxt_pulse;

  // ==========================================================================
  // countdown from release; readdressing the same strip cancels it
  always_comb begin
    nxt_cnt   = cnt_ff;
    nxt_arm   = arm_ff;
    nxt_unit  = unit_ff;
    nxt_pulse = 1'b0;
    if (release_i && strip_i) begin
      nxt_arm  = 1'b1;
      nxt_unit = unit_i;
      nxt_cnt  = 25'(RESTORE_CYC);
    end else if (arm_ff) begin
      if (readdress_i && unit_i == unit_ff) begin
        nxt_arm = 1'b0;
      end else if (cnt_ff <= 25'h0000001) begin
        nxt_arm   = 1'b0;
        nxt_pulse = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - 25'h0000001;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cnt_ff   <= 25'h0000000;
      arm_ff   <= 1'b0;
      unit_ff  <= 2'h0;
      pulse_ff <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      arm_ff   <= nxt_arm;
      unit_ff  <= nxt_unit;
      pulse_ff <= nxt_pulse;
    end
  end

  assign restore_o      = pulse_ff;
  assign restore_unit_o = unit_ff;

endmodule // scie_restore_tmr
`default_nettype wire

/* scie_ctrl.sv */
`default_nettype none
// How it works
// - released strip restores unless same strip readdressed within 16 revolutions (800 ms)
// - interrupt output drops on clear, release-disconnect, or any new function code
// - clears and release-disconnect remove all selections; release keeps opposite-release
// - clears remove opposite-release selection only when other channel holds no reservation
// - each selection has a release code removing just that selection
// - reserving channel gets all interrupts; other gets only opposite-release
// - address error or not-ready: hang busy, or send lockout override if abnormal selected
// - starting any I/O code seeks to the address register location
// - header verify at next sector; new off-cylinder unit needs seek and verify
// - address advances each sector except on address error or selected abnormal
// - on-sector holds until read, write, seek, drive/controller release or clear
// - only first on-sector sets seek interrupt until an operation finishes
// - any function clears pending interrupt, even if coincident with on-sector
// - seek keeps busy but accepts new connect/function once pulse sent
// - address and I/O codes must be last; all but checkword verify need transfer
// - end-of-record mode pads short sector with zeros and writes record mark
// - every received byte is parity checked and lights indicator on mismatch
// - connect parity error: never connects and drops any link held; no reply, reject or error
// - function parity error: signal error, discard function, no reply or reject
// - data parity error: signal error but reply and use byte
// - on-sector only after positioner-ready has asserted
module scie_ctrl
  import scie_pkg::*;
#(
  parameter int unsigned RESTORE_CYC = RESTORE_CYCLES
) (
  input  wire logic                mclk_i,
  input  wire logic                rst_n_i,
  input  wire logic                master_clear_i,
  input  wire scie_chan_req_t      chan_a_req_i,
  input  wire scie_chan_req_t      chan_b_req_i,
  output scie_chan_rsp_t           chan_a_rsp_o,
  output scie_chan_rsp_t           chan_b_rsp_o,
  input  wire logic [UNIT_N-1:0]   pos_ready_i,
  input  wire logic [UNIT_N-1:0]   seek_done_i,
  input  wire logic                sector_end_i,
  input  wire logic                addr_err_i,
  input  wire logic                not_ready_i,
  input  wire logic                abnormal_i,
  input  wire logic                strip_unit_i,
  input  wire logic                eor_mode_i,
  input  wire logic                out_done_i,
  output logic [UNIT_N-1:0]        on_sector_o,
  output logic                     seek_pulse_o,
  output logic                     verify_o,
  output logic                     pad_zero_o,
  output logic                     record_mark_o,
  output logic [ADDR_W-1:0]        addr_o,
  output logic [UNIT_W-1:0]        unit_o,
  output logic                     busy_o,
  output logic                     reserved_a_o,
  output logic                     reserved_b_o,
  output logic                     parity_lamp_o,
  output logic                     restore_o,
  output logic [UNIT_W-1:0]        restore_unit_o
);

  // ==========================================================================
  // pin synchronisers
  logic [UNIT_N-1:0] posr_s1_ff, posr_ff, seek_s1_ff, seek_ff;
  logic              mc_s1_ff, mc_ff;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      posr_s1_ff <= 4'h0;
      posr_ff    <= 4'h0;
      seek_s1_ff <= 4'h0;
      seek_ff    <= 4'h0;
      mc_s1_ff   <= 1'b0;
      mc_ff      <= 1'b0;
    end else begin
      posr_s1_ff <= pos_ready_i;
      posr_ff    <= posr_s1_ff;
      seek_s1_ff <= seek_done_i;
      seek_ff    <= seek_s1_ff;
      mc_s1_ff   <= master_clear_i;
      mc_ff      <= mc_s1_ff;
    end
  end

  // ==========================================================================
  // request arbitration: channel a wins a tie, as the first recognised
  scie_chan_req_t req;
  logic           from_b;
  logic           a_conn_err, a_fn_err, a_data_err, a_lamp;
  logic           b_conn_err, b_fn_err, b_data_err, b_lamp;

  scie_parity_chk u_par_a (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .req_i       (chan_a_req_i),
    .conn_err_o  (a_conn_err),
    .fn_err_o    (a_fn_err),
    .data_err_o  (a_data_err),
    .indicator_o (a_lamp)
  );

  scie_parity_chk u_par_b (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .req_i       (chan_b_req_i),
    .conn_err_o  (b_conn_err),
    .fn_err_o    (b_fn_err),
    .data_err_o  (b_data_err),
    .indicator_o (b_lamp)
  );

  assign parity_lamp_o = a_lamp | b_lamp;

  // ==========================================================================
  // state
  logic [1:0]         res_ff, nxt_res;       // [0] channel a, [1] channel b
  logic [SEL_N-1:0]   sel_ff, nxt_sel;
  logic [1:0]         oppsel_ff, nxt_oppsel; // opposite-release per channel
  logic               pend_ff, nxt_pend;
  logic               seek_arm_ff, nxt_seek_arm;
  logic [UNIT_N-1:0]  onsec_ff, nxt_onsec;
  logic [UNIT_N-1:0]  seeking_ff, nxt_seeking;
  logic [ADDR_W-1:0]  addr_ff, nxt_addr;
  logic [UNIT_W-1:0]  unit_ff, nxt_unit, last_unit_ff, nxt_last_unit;
  logic               hang_ff, nxt_hang;
  logic               abn_ff, nxt_abn;
  logic [1:0]         opp_irq_ff, nxt_opp_irq;
  scie_op_state_t     st_ff, nxt_st;
  scie_chan_rsp_t     rsp_a_ff, nxt_rsp_a, rsp_b_ff, nxt_rsp_b;
  logic               seek_pulse_ff, nxt_seek_pulse;

  logic        cur_conn_err, cur_fn_err, cur_data_err;
  logic        is_fn, is_clear, is_release, is_rel_sel, is_sel, is_io, is_addr;
  logic        chan_mine, clears, finish, fin_evt;
  logic [5:0]  grp;
  logic [SEL_W-1:0] sel_idx;

  always_comb begin
    from_b       = !chan_a_req_i.valid && chan_b_req_i.valid;
    req          = from_b ? chan_b_req_i : chan_a_req_i;
    cur_conn_err = from_b ? b_conn_err : a_conn_err;
    cur_fn_err   = from_b ? b_fn_err : a_fn_err;
    cur_data_err = from_b ? b_data_err : a_data_err;
    grp          = req.word[BYTE_W-1:6];
    sel_idx      = req.word[SEL_W-1:0];
    chan_mine    = from_b ? res_ff[1] : res_ff[0];
    is_fn        = req.valid && req.is_function && chan_mine && !cur_fn_err;
    is_clear     = is_fn && grp == FN_CLEAR;
    is_release   = is_fn && grp == FN_RELEASE;
    is_sel       = is_fn && grp == FN_GROUP_SEL;
    is_rel_sel   = is_fn && grp == FN_GROUP_REL;
    is_io        = is_fn && grp == FN_GROUP_IO;
    is_addr      = is_fn && grp == FN_GROUP_ADDR;
    clears       = mc_ff || is_clear;
    fin_evt      = sector_end_i && (st_ff == SCIE_XFER) && out_done_i;
    finish       = fin_evt || st_ff == SCIE_PAD;
  end

  // ==========================================================================
  // next-state logic
  always_comb begin
    nxt_res        = res_ff;
    nxt_sel        = sel_ff;
    nxt_oppsel     = oppsel_ff;
    nxt_pend       = pend_ff;
    nxt_seek_arm   = seek_arm_ff;
    nxt_onsec      = onsec_ff;
    nxt_seeking    = seeking_ff;
    nxt_addr       = addr_ff;
    nxt_unit       = unit_ff;
    nxt_last_unit  = last_unit_ff;
    nxt_hang       = hang_ff;
    nxt_abn        = abn_ff;
    nxt_opp_irq    = opp_irq_ff;
    nxt_st         = st_ff;
    nxt_rsp_a      = '0;
    nxt_rsp_b      = '0;
    nxt_seek_pulse = 1'b0;

    // on-sector tracking per unit
    for (int u = 0; u < UNIT_N; u++) begin
      if (seeking_ff[u] && seek_ff[u] && posr_ff[u]) begin
        nxt_onsec[u]   = 1'b1;
        nxt_seeking[u] = 1'b0;
        if (seek_arm_ff && sel_ff[SEL_SEEK]) begin
          nxt_pend     = 1'b1;
          nxt_seek_arm = 1'b0;
        end
      end
    end

    // transfer sequencing
    case (st_ff)
      SCIE_IDLE:   nxt_st = SCIE_IDLE;
      SCIE_SEEK: begin
        if (posr_ff[unit_ff]) begin
          nxt_st = SCIE_VERIFY;
        end
      end
      SCIE_VERIFY: begin
        if (sector_end_i) begin
          nxt_st = SCIE_XFER;
        end
      end
      SCIE_XFER: begin
        if (sector_end_i) begin
          if (!(addr_err_i || (abnormal_i && sel_ff[SEL_ABN_FINISH]))) begin
            nxt_addr = addr_ff + 24'h000001;
          end
          if (out_done_i) begin
            nxt_st = eor_mode_i ? SCIE_PAD : SCIE_IDLE;
          end
        end else if (out_done_i && eor_mode_i) begin
          nxt_st = SCIE_PAD;
        end
      end
      SCIE_PAD: begin
        if (sector_end_i) begin
          nxt_addr = addr_ff + 24'h000001;
          nxt_st   = SCIE_IDLE;
        end
      end
      default:     nxt_st = SCIE_IDLE;
    endcase

    if (finish && nxt_st == SCIE_IDLE) begin
      nxt_seek_arm = 1'b1;
      if (sel_ff[SEL_FINISH]) begin
        nxt_pend = 1'b1;
      end
    end

    // error handling
    if ((addr_err_i || not_ready_i) && st_ff != SCIE_IDLE) begin
      nxt_st = SCIE_IDLE;
      if (sel_ff[SEL_ABN_FINISH]) begin
        nxt_abn  = 1'b1;
        nxt_pend = 1'b1;
      end else begin
        nxt_hang = 1'b1;
      end
    end

    // connect: parity error drops the link silently
    if (req.valid && req.is_connect) begin
      if (cur_conn_err) begin
        if (from_b) nxt_res[1] = 1'b0;
        else        nxt_res[0] = 1'b0;
      end else if (res_ff == 2'b00) begin
        nxt_res = from_b ? 2'b10 : 2'b01;
        if (from_b) nxt_rsp_b.reply = 1'b1;
        else        nxt_rsp_a.reply = 1'b1;
      end else if (!chan_mine) begin
        if (from_b) nxt_rsp_b.reject = 1'b1;
        else        nxt_rsp_a.reject = 1'b1;
      end else begin
        if (from_b) nxt_rsp_b.reply = 1'b1;
        else        nxt_rsp_a.reply = 1'b1;
      end
    end

    // function and data answers
    if (req.valid && (req.is_function || req.is_data)) begin
      if (from_b) begin
        nxt_rsp_b.link_par_err = cur_fn_err || cur_data_err;
        nxt_rsp_b.reply        = chan_mine && !cur_fn_err;
      end else begin
        nxt_rsp_a.link_par_err = cur_fn_err || cur_data_err;
        nxt_rsp_a.reply        = chan_mine && !cur_fn_err;
      end
    end

    if (is_fn) begin
      nxt_pend = 1'b0;
      nxt_abn  = 1'b0;
      if (is_sel && sel_idx == 3'(SEL_OPP_REL)) begin
        nxt_oppsel[from_b] = 1'b1;
      end else if (is_sel && 32'(sel_idx) < SEL_N) begin
        nxt_sel[sel_idx] = 1'b1;
      end
      if (is_rel_sel && sel_idx == 3'(SEL_OPP_REL)) begin
        nxt_oppsel[from_b] = 1'b0;
      end else if (is_rel_sel && 32'(sel_idx) < SEL_N) begin
        nxt_sel[sel_idx] = 1'b0;
      end
      if (is_addr) begin
        nxt_unit          = req.word[UNIT_W-1:0];
        nxt_seeking[nxt_unit] = 1'b1;
        nxt_onsec[nxt_unit]   = 1'b0;
        nxt_seek_pulse    = 1'b1;
      end
      if (is_io && req.word != FN_CKW_VERIFY) begin
        nxt_onsec[unit_ff] = 1'b0;
        nxt_seek_pulse     = 1'b1;
        nxt_last_unit      = unit_ff;
        nxt_st = (unit_ff != last_unit_ff && !posr_ff[unit_ff]) ? SCIE_SEEK
                                                                  : SCIE_VERIFY;
      end
    end

    if (is_release) begin
      nxt_sel   = '0;
      nxt_onsec = 4'h0;
      nxt_pend  = 1'b0;
      nxt_hang  = 1'b0;
      nxt_res[from_b] = 1'b0;
      nxt_opp_irq[!from_b] = oppsel_ff[!from_b];
    end

    if (clears) begin
      nxt_sel   = '0;
      nxt_pend  = 1'b0;
      nxt_abn   = 1'b0;
      nxt_hang  = 1'b0;
      nxt_onsec = 4'h0;
      nxt_st    = SCIE_IDLE;
      nxt_addr  = ADDR_RESET;
      for (int c = 0; c < 2; c++) begin
        if (!res_ff[1-c]) nxt_oppsel[c] = 1'b0;
      end
      nxt_opp_irq = 2'b00;
      if (mc_ff) nxt_res = 2'b00;
    end

    if (req.valid && req.is_function && !cur_fn_err) begin
      nxt_opp_irq[from_b] = 1'b0;
    end

    // only reserving channel sees selected interrupts
    nxt_rsp_a.irq = (res_ff[0] && pend_ff) || opp_irq_ff[0];
    nxt_rsp_b.irq = (res_ff[1] && pend_ff) || opp_irq_ff[1];
    nxt_rsp_a.lockout_override = res_ff[0] && abn_ff;
    nxt_rsp_b.lockout_override = res_ff[1] && abn_ff;
  end

  // ==========================================================================
  // registers
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      res_ff        <= 2'h0;
      sel_ff        <= 5'h00;
      oppsel_ff     <= 2'h0;
      pend_ff       <= 1'b0;
      seek_arm_ff   <= 1'b1;
      onsec_ff      <= 4'h0;
      seeking_ff    <= 4'h0;
      addr_ff       <= ADDR_RESET;
      unit_ff       <= 2'h0;
      last_unit_ff  <= 2'h0;
      hang_ff       <= 1'b0;
      abn_ff        <= 1'b0;
      opp_irq_ff    <= 2'h0;
      st_ff         <= SCIE_IDLE;
      rsp_a_ff      <= '0;
      rsp_b_ff      <= '0;
      seek_pulse_ff <= 1'b0;
    end else begin
      res_ff        <= nxt_res;
      sel_ff        <= nxt_sel;
      oppsel_ff     <= nxt_oppsel;
      pend_ff       <= nxt_pend;
      seek_arm_ff   <= nxt_seek_arm;
      onsec_ff      <= nxt_onsec;
      seeking_ff    <= nxt_seeking;
      addr_ff       <= nxt_addr;
      unit_ff       <= nxt_unit;
      last_unit_ff  <= nxt_last_unit;
      hang_ff       <= nxt_hang;
      abn_ff        <= nxt_abn;
      opp_irq_ff    <= nxt_opp_irq;
      st_ff         <= nxt_st;
      rsp_a_ff      <= nxt_rsp_a;
      rsp_b_ff      <= nxt_rsp_b;
      seek_pulse_ff <= nxt_seek_pulse;
    end
  end

  // ==========================================================================
  // strip restore
  scie_restore_tmr #(
    .RESTORE_CYC (RESTORE_CYC)
  ) u_restore (
    .mclk_i         (mclk_i),
    .rst_n_i        (rst_n_i),
    .strip_i        (strip_unit_i),
    .release_i      (is_release),
    .readdress_i    (is_addr),
    .unit_i         (is_addr ? req.word[UNIT_W-1:0] : unit_ff),
    .restore_o      (restore_o),
    .restore_unit_o (restore_unit_o)
  );

  // ==========================================================================
  // outputs
  assign chan_a_rsp_o  = rsp_a_ff;
  assign chan_b_rsp_o  = rsp_b_ff;
  assign on_sector_o   = onsec_ff;
  assign seek_pulse_o  = seek_pulse_ff;
  assign verify_o      = (st_ff == SCIE_VERIFY);
  assign pad_zero_o    = (st_ff == SCIE_PAD);
  assign record_mark_o = (st_ff == SCIE_PAD) && sector_end_i;
  assign addr_o        = addr_ff;
  assign unit_o        = unit_ff;
  // seeks hold busy while the channel may still talk to us
  assign busy_o        = hang_ff || (st_ff != SCIE_IDLE) || (|seeking_ff);
  assign reserved_a_o  = res_ff[0];
  assign reserved_b_o  = res_ff[1];

endmodule // scie_ctrl
`default_nettype wire

/* scie_chan_model.sv */
`default_nettype none
module scie_chan_model
  import scie_pkg::*;
(
  input  wire logic           mclk_i,
  input  wire scie_chan_rsp_t rsp_i,
  output scie_chan_req_t      req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====
  // one byte per call: k = connect, function, data
  initial req_o = '0;
  task automatic send(input logic [2:0] k, input logic [11:0] w, input logic bad,
                      output scie_chan_rsp_t r);
    @(posedge mclk_i);
    req_o <= {1'b1, k, w, (~^w) ^ bad};
    @(posedge mclk_i);
    // released lines show the inverse so a stale byte never looks current
    req_o <= {4'h0, ~w, 1'b0};
    #1 r = rsp_i;
  endtask
endmodule // scie_chan_model
`default_nettype wire

/* scie_ctrl_monitor.sv */
`default_nettype none
module scie_ctrl_monitor
  import scie_pkg::*;
#(
  parameter int unsigned RESTORE_CYC = RESTORE_CYCLES
) (
  input wire logic              mclk_i,
  input wire logic              rst_n_i,
  input wire logic              master_clear_i,
  input wire scie_chan_req_t    chan_a_req_i,
  input wire scie_chan_req_t    chan_b_req_i,
  input wire scie_chan_rsp_t    chan_a_rsp_o,
  input wire scie_chan_rsp_t    chan_b_rsp_o,
  input wire logic [UNIT_N-1:0] pos_ready_i,
  input wire logic [UNIT_N-1:0] on_sector_o,
  input wire logic              seek_pulse_o,
  input wire logic              busy_o,
  input wire logic              reserved_a_o,
  input wire logic              parity_lamp_o,
  input wire logic              restore_o
);
  // ====
  logic a_bad;
  logic b_bad;
  assign a_bad = chan_a_req_i.valid && chan_a_req_i.par == ^chan_a_req_i.word;
  assign b_bad = chan_b_req_i.valid && chan_b_req_i.par == ^chan_b_req_i.word;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  chk_conn_par_quiet: assert property (a_bad && chan_a_req_i.is_connect |=>
    !chan_a_rsp_o.reply && !chan_a_rsp_o.reject && !chan_a_rsp_o.link_par_err)
    else $error("connect parity error answered");
  chk_fn_par_flag: assert property (a_bad && chan_a_req_i.is_function |=>
    chan_a_rsp_o.link_par_err && !chan_a_rsp_o.reply && !chan_a_rsp_o.reject)
    else $error("function parity error handling wrong");
  chk_data_par_reply: assert property (a_bad && chan_a_req_i.is_data && reserved_a_o
    |=> chan_a_rsp_o.link_par_err && chan_a_rsp_o.reply)
    else $error("data parity error handling wrong");
  chk_lamp_lights: assert property (a_bad || b_bad |-> ##[1:2] parity_lamp_o)
    else $error("parity lamp not lit");
  chk_fn_drops_irq: assert property (chan_a_req_i.valid && chan_a_req_i.is_function
    && !a_bad && reserved_a_o |-> ##[1:2] !chan_a_rsp_o.irq)
    else $error("function did not drop interrupt");
  chk_clear_drops_irq: assert property (master_clear_i [*6] |->
    !chan_a_rsp_o.irq && !chan_b_rsp_o.irq && !reserved_a_o)
    else $error("master clear left interrupt or reservation");
  chk_sector_after_ready: assert property
    ((on_sector_o & ~$past(on_sector_o) & ~$past(pos_ready_i, 2)) == '0)
    else $error("on sector before positioner ready");
  chk_seek_busy: assert property (seek_pulse_o |-> busy_o ##1 !seek_pulse_o)
    else $error("seek pulse without busy");
  chk_restore_pulse: assert property (restore_o |=> !restore_o)
    else $error("restore pulse too long");
endmodule // scie_ctrl_monitor
bind scie_ctrl scie_ctrl_monitor #(.RESTORE_CYC(RESTORE_CYC)) mon (.mclk_i(mclk_i),
  .rst_n_i(rst_n_i), .master_clear_i(master_clear_i), .chan_a_req_i(chan_a_req_i),
  .chan_b_req_i(chan_b_req_i), .chan_a_rsp_o(chan_a_rsp_o), .chan_b_rsp_o(chan_b_rsp_o),
  .pos_ready_i(pos_ready_i), .on_sector_o(on_sector_o), .seek_pulse_o(seek_pulse_o),
  .busy_o(busy_o), .reserved_a_o(reserved_a_o), .parity_lamp_o(parity_lamp_o),
  .restore_o(restore_o));
`default_nettype wire

/* scie_ctrl_bench.sv */
`default_nettype none
module scie_ctrl_bench
  import scie_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ====
  localparam int unsigned RC = 20;
  logic mclk_i, rst_n_i, master_clear_i, strip_unit_i, sector_end_i;
  logic [UNIT_N-1:0] pos_ready_i, seek_done_i, on_sector_o;
  logic [ADDR_W-1:0] addr_o;
  logic [2:0] sc = 3'h0;
  logic seek_pulse_o, busy_o, reserved_a_o, reserved_b_o, parity_lamp_o, restore_o;
  scie_chan_req_t chan_a_req_i, chan_b_req_i;
  scie_chan_rsp_t chan_a_rsp_o, chan_b_rsp_o, ra, rb;
  int fails, checked, n;
  scie_ctrl #(.RESTORE_CYC(RC)) dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .master_clear_i(master_clear_i), .chan_a_req_i(chan_a_req_i),
    .chan_b_req_i(chan_b_req_i), .chan_a_rsp_o(chan_a_rsp_o), .chan_b_rsp_o(chan_b_rsp_o),
    .pos_ready_i(pos_ready_i), .seek_done_i(seek_done_i), .sector_end_i(sector_end_i),
    .addr_err_i(1'b0), .not_ready_i(1'b0), .abnormal_i(1'b0), .strip_unit_i(strip_unit_i),
    .eor_mode_i(1'b0), .out_done_i(1'b0), .on_sector_o(on_sector_o),
    .seek_pulse_o(seek_pulse_o), .verify_o(), .pad_zero_o(), .record_mark_o(),
    .addr_o(addr_o), .unit_o(), .busy_o(busy_o), .reserved_a_o(reserved_a_o),
    .reserved_b_o(reserved_b_o), .parity_lamp_o(parity_lamp_o), .restore_o(restore_o),
    .restore_unit_o());
  scie_chan_model ch_a (.mclk_i(mclk_i), .rsp_i(chan_a_rsp_o), .req_o(chan_a_req_i));
  scie_chan_model ch_b (.mclk_i(mclk_i), .rsp_i(chan_b_rsp_o), .req_o(chan_b_req_i));
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    sc <= sc + 3'h1;
    sector_end_i <= (sc == 3'h0);
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic stop_test();
    if (fails == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wait_sector(input int u);
    n = 0;
    while (on_sector_o[u] !== 1'b1 && n < 30) begin
      @(negedge mclk_i);
      n++;
    end
  endtask
  task automatic t_parity();
    ch_a.send(3'h4, 12'h010, 1'b1, ra);
    chk("conn_bad_rsp", 0, ra);
    chk("conn_bad_res", 0, reserved_a_o);
    ch_a.send(3'h4, 12'h010, 1'b0, ra);
    chk("reserved_a", 1, reserved_a_o);
    ch_b.send(3'h4, 12'h010, 1'b0, rb);
    chk("b_reject", 1, rb.reject);
    ch_a.send(3'h2, 12'h080, 1'b1, ra);
    chk("fn_bad_rsp", 5'h04, ra);
    ch_a.send(3'h1, 12'h155, 1'b1, ra);
    chk("data_bad_rsp", 5'h14, ra);
    chk("lamp", 1, parity_lamp_o);
  endtask
  task automatic t_seek();
    ch_a.send(3'h2, 12'h083, 1'b0, ra);
    ch_a.send(3'h2, 12'h041, 1'b0, ra);
    chk("seek_busy", 1, busy_o);
    @(posedge mclk_i);
    pos_ready_i[1] <= 1'b1;
    seek_done_i[1] <= 1'b1;
    wait_sector(1);
    repeat (3) @(negedge mclk_i);
    chk("seek_irq_a", 1, chan_a_rsp_o.irq);
    chk("seek_irq_b", 0, chan_b_rsp_o.irq);
    ch_a.send(3'h2, 12'h042, 1'b0, ra);
    @(posedge mclk_i);
    pos_ready_i[2] <= 1'b1;
    seek_done_i[2] <= 1'b1;
    wait_sector(2);
    repeat (3) @(negedge mclk_i);
    chk("second_irq", 0, chan_a_rsp_o.irq);
    chk("sector1_held", 1, on_sector_o[1]);
    ch_a.send(3'h2, 12'h0c3, 1'b0, ra);
    ch_a.send(3'h2, 12'h082, 1'b0, ra);
  endtask
  task automatic t_opp();
    ch_a.send(3'h2, 12'h084, 1'b0, ra);
    ch_a.send(3'h2, 12'h140, 1'b0, ra);
    chk("a_released", 0, reserved_a_o);
    ch_b.send(3'h4, 12'h010, 1'b0, rb);
    ch_b.send(3'h2, 12'h140, 1'b0, rb);
    repeat (3) @(negedge mclk_i);
    chk("opp_irq_a", 1, chan_a_rsp_o.irq);
    ch_a.send(3'h4, 12'h010, 1'b0, ra);
    ch_a.send(3'h2, 12'h0c4, 1'b0, ra);
    repeat (2) @(negedge mclk_i);
    chk("opp_irq_off", 0, chan_a_rsp_o.irq);
  endtask
  task automatic t_restore();
    @(posedge mclk_i);
    strip_unit_i <= 1'b1;
    ch_a.send(3'h2, 12'h040, 1'b0, ra);
    ch_a.send(3'h2, 12'h140, 1'b0, ra);
    n = 0;
    while (restore_o !== 1'b1 && n < RC + 20) begin
      @(negedge mclk_i);
      n++;
    end
    chk("restore", 1, restore_o);
    chk("restore_early", 1, n + 4 >= RC);
  endtask
  task automatic t_mclear();
    ch_a.send(3'h4, 12'h010, 1'b0, ra);
    @(posedge mclk_i);
    master_clear_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    master_clear_i <= 1'b0;
    @(negedge mclk_i);
    chk("mc_reserved", 0, reserved_a_o);
    chk("mc_addr", 0, addr_o);
  endtask
  initial begin
    {master_clear_i, strip_unit_i, rst_n_i} = 3'h0;
    {pos_ready_i, seek_done_i} = 8'h00;
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_parity();
    t_seek();
    t_opp();
    t_restore();
    t_mclear();
    stop_test();
  end
  initial begin
    repeat (3000) @(posedge mclk_i);
    fails++;
    stop_test();
  end
endmodule // scie_ctrl_bench
`default_nettype wire
